// *** src/pm_pkg.sv ***
/*
 * Constants, register map and types for the host and line-driver pin
 * function multiplexer.
 * Assumes a single 40 MHz core clock and a synchronous active-low reset.
 */
package pm_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	// Strap sampling window after reset release (least time)
	localparam int STRAP_CAPTURE_NS = 250;
	localparam int STRAP_CYCLES = (STRAP_CAPTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAP_W = 4;
	localparam logic [CAP_W-1:0] CAP_LOAD = CAP_W'(STRAP_CYCLES - 1);
	// Fastest multiplexed-bus clock the host may supply
	localparam int HOST_CLK_MAX_KHZ = 8000;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
	localparam logic [ADDR_W-1:0] REG_DRIVE = 4'h1;
	localparam logic [ADDR_W-1:0] REG_PULL_EN = 4'h2;
	localparam logic [ADDR_W-1:0] REG_PULL_UP = 4'h3;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	localparam int CFG_W = 10;
	localparam int CFG_LDT_LSB = 0;
	localparam int CFG_STB1_LSB = 2;
	localparam int CFG_STB2_LSB = 5;
	localparam int CFG_STB1_EN = 8;
	localparam int CFG_STB2_EN = 9;
	localparam logic [1:0] LDT_TRANSCEIVER = 2'h0;
	localparam int DRV_W = 6;
	localparam int DRV_DATA = 0;
	localparam int DRV_STRAP = 1;
	localparam int DRV_CKOUT = 5;
	localparam int PULL_W = 9;
	localparam int ST_IF_LSB = 0;
	localparam int ST_CLK_LSB = 2;
	localparam int ST_ASYNC = 4;
	localparam int ST_BUSY = 5;
	localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;
	localparam logic [DRV_W-1:0] DRV_RESET = 6'h00;
	localparam logic [PULL_W-1:0] PULL_RESET = 9'h000;

	// ------------------------------------------------------------
	// Shared strap pins and synchroniser layout
	// ------------------------------------------------------------
	localparam int SP_TICK = 0;
	localparam int SP_TX_ONE = 1;
	localparam int SP_ARM = 2;
	localparam int SP_MACROTICK = 3;
	localparam int SY_ADDR = 0;
	localparam int SY_ASEL = 6;
	localparam int SY_OE = 9;
	localparam int SY_ASEL_HI = 10;
	localparam int SY_DATA = 12;
	localparam int SY_CE = 28;
	localparam int SY_WE = 29;
	localparam int SY_HCLK = 30;
	localparam int SY_RX = 31;
	localparam int SY_STRAP = 33;
	localparam int SY_W = 37;

	typedef enum logic [0:0] {PM_CAPTURE, PM_RUN} pm_phase_t;

endpackage : pm_pkg

// *** src/pm_pin_mux.sv ***
/*
 * Pin function multiplexer of the communication controller: host port role
 * selection, strap capture, guardian/debug pin sharing, receive routing and
 * pad drive/pull control.
 * Assumes every pin input is asynchronous to clk and that core-side signals
 * are on clk.
 */
module pm_pin_mux
	import pm_pkg::*;
#(
	// Interface strap code -> 1 selects async memory port
	parameter logic [3:0] IF_ASYNC_LUT = 4'h1,
	// Clock strap code -> half period in clk cycles, 8 bits per code
	parameter logic [31:0] CLK_DIV_LUT = 32'h08040201,
	parameter int DBG_EVENTS = 8,
	parameter int DBG_SEL_W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [pm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [pm_pkg::DATA_W-1:0] reg_rdata,
	// Host pins
	input wire logic [5:0] addr_pin_in,
	input wire logic [2:0] asel_low_pin_in,
	input wire logic oe_asel3_pin_in,
	input wire logic [1:0] asel_high_pin_in,
	input wire logic [15:0] data_pin_in,
	output logic [15:0] data_pin_out,
	output logic data_pin_oe,
	input wire logic ce_lbs_pin_in,
	input wire logic we_rw_pin_in,
	input wire logic host_bus_clock_in,
	// Async memory port to core
	output logic async_memory_host_mode,
	output logic [8:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic mem_we,
	output logic size_select_n,
	input wire logic [15:0] mem_rdata,
	// Multiplexed bus to core
	output logic [5:0] expanded_address_line,
	output logic [5:0] address_select_input,
	output logic [15:0] mux_ad,
	output logic low_byte_strobe,
	output logic read_write_select,
	output logic host_bus_clock,
	input wire logic mux_drive_req,
	// Shared guardian / debug / strap pins
	input wire logic guardian_tick_out,
	input wire logic guardian_macrotick_out,
	input wire logic guardian_arm_out,
	input wire logic tx_data_one,
	input wire logic [DBG_EVENTS-1:0] debug_event,
	input wire logic [3:0] strap_pin_in,
	output logic [3:0] strap_pin_out,
	output logic [3:0] strap_pin_oe,
	output logic [3:0] strap_pin_pd,
	// Clock output
	output logic external_clock_output,
	// Receive data
	input wire logic [1:0] rx_pin_in,
	output logic [1:0] transceiver_receive_data,
	output logic [1:0] differential_receive_data,
	// Pad controls
	output logic [pm_pkg::DRV_W-1:0] drive_reduced,
	output logic [pm_pkg::PULL_W-1:0] pull_enable,
	output logic [pm_pkg::PULL_W-1:0] pull_up_select
);
	import pm_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [SY_W-1:0] s1;
		logic [SY_W-1:0] s2;
		logic [SY_W-1:0] s3;
		pm_phase_t phase;
		logic [CAP_W-1:0] cap_cnt;
		logic [1:0] if_strap;
		logic [1:0] clk_strap;
		logic async_mode;
		logic [CFG_W-1:0] cfg;
		logic [DRV_W-1:0] drv;
		logic [PULL_W-1:0] pen;
		logic [PULL_W-1:0] pup;
		logic [DATA_W-1:0] rdata;
		logic [8:0] maddr;
		logic [15:0] mwdata;
		logic mwe;
		logic size_n;
		logic [15:0] dout;
		logic doe;
		logic [5:0] xal;
		logic [5:0] asel;
		logic [15:0] ad;
		logic lbs;
		logic rw;
		logic hclk;
		logic [3:0] sp_out;
		logic [3:0] sp_oe;
		logic [3:0] sp_pd;
		logic [7:0] div_cnt;
		logic ckout;
		logic [1:0] rx_trx;
		logic [1:0] rx_diff;
	} pm_regs_t;

	pm_regs_t q;
	pm_regs_t d;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] div_half(input logic [1:0] code);
		div_half = CLK_DIV_LUT[{code, 3'h0} +: 8];
	endfunction : div_half

	function automatic logic dbg_pick(input logic [DBG_EVENTS-1:0] ev,
		input logic [DBG_SEL_W-1:0] sel);
		dbg_pick = ev[sel];
	endfunction : dbg_pick

	logic [SY_W-1:0] sync_in;
	logic we_rise;
	logic [DBG_SEL_W-1:0] stb1_sel, stb2_sel;

	assign sync_in = {strap_pin_in, rx_pin_in, host_bus_clock_in, we_rw_pin_in,
		ce_lbs_pin_in, data_pin_in, asel_high_pin_in, oe_asel3_pin_in,
		asel_low_pin_in, addr_pin_in};
	// Data is taken when the strobe ends, where it is known to be settled
	assign we_rise = q.s2[SY_WE] && !q.s3[SY_WE] && !q.s3[SY_CE];
	assign stb1_sel = q.cfg[CFG_STB1_LSB +: DBG_SEL_W];
	assign stb2_sel = q.cfg[CFG_STB2_LSB +: DBG_SEL_W];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.s1 = sync_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.rdata = '0;
		d.mwe = 1'b0;

		// Strap window: pins released and pulled down until latched
		case (q.phase)
			PM_CAPTURE: begin
				d.sp_out = 4'h0;
				d.sp_oe = 4'h0;
				d.sp_pd = 4'hF;
				if (q.cap_cnt == '0) begin
					d.if_strap = q.s2[SY_STRAP +: 2];
					d.clk_strap = q.s2[SY_STRAP + 2 +: 2];
					d.async_mode = IF_ASYNC_LUT[q.s2[SY_STRAP +: 2]];
					d.phase = PM_RUN;
				end else begin
					d.cap_cnt = q.cap_cnt - 1'b1;
				end
			end
			PM_RUN: begin
				d.sp_oe = 4'hF;
				d.sp_pd = 4'h0;
				// Guardian functions ignore the line driver type
				d.sp_out[SP_TICK] = q.cfg[CFG_STB2_EN] ? dbg_pick(debug_event, stb2_sel)
					: guardian_tick_out;
				d.sp_out[SP_ARM] = q.cfg[CFG_STB1_EN] ? dbg_pick(debug_event, stb1_sel)
					: guardian_arm_out;
				d.sp_out[SP_MACROTICK] = guardian_macrotick_out;
				d.sp_out[SP_TX_ONE] = tx_data_one;
			end
			default: begin
				d.phase = PM_CAPTURE;
			end
		endcase

		// Clock output divider keeps running through the strap window
		if (q.div_cnt == 8'h00) begin
			d.ckout = ~q.ckout;
			d.div_cnt = div_half(q.clk_strap) - 8'h01;
		end else begin
			d.div_cnt = q.div_cnt - 8'h01;
		end

		// Host port roles
		d.doe = 1'b0;
		d.xal = '0;
		d.asel = '0;
		d.ad = '0;
		d.lbs = 1'b0;
		d.rw = 1'b0;
		d.hclk = 1'b0;
		d.size_n = 1'b1;
		if (q.phase == PM_RUN && q.async_mode) begin
			// Read drive follows output enable and chip enable, both low
			d.doe = !q.s2[SY_OE] && !q.s2[SY_CE];
			d.dout = mem_rdata;
			d.size_n = q.s2[SY_CE];
			if (we_rise) begin
				d.mwe = 1'b1;
				d.maddr = {q.s3[SY_ASEL +: 3], q.s3[SY_ADDR +: 6]};
				d.mwdata = q.s3[SY_DATA +: 16];
			end
		end else if (q.phase == PM_RUN) begin
			d.doe = mux_drive_req;
			d.dout = mem_rdata;
			d.xal = q.s2[SY_ADDR +: 6];
			d.asel = {q.s2[SY_ASEL_HI +: 2], q.s2[SY_OE], q.s2[SY_ASEL +: 3]};
			d.ad = q.s2[SY_DATA +: 16];
			d.lbs = q.s2[SY_CE];
			d.rw = q.s2[SY_WE];
			// Sampled at 40 MHz; valid only up to the 8 MHz host limit
			d.hclk = q.s2[SY_HCLK];
		end

		// Receive routing; idle channel parks at recessive high
		if (q.cfg[CFG_LDT_LSB +: 2] == LDT_TRANSCEIVER) begin
			d.rx_trx = q.s2[SY_RX +: 2];
			d.rx_diff = 2'h3;
		end else begin
			d.rx_trx = 2'h3;
			d.rx_diff = q.s2[SY_RX +: 2];
		end

		// Register port
		if (reg_we) begin
			case (reg_addr)
				REG_CONFIG: d.cfg = reg_wdata[CFG_W-1:0];
				REG_DRIVE: d.drv = reg_wdata[DRV_W-1:0];
				REG_PULL_EN: d.pen = reg_wdata[PULL_W-1:0];
				REG_PULL_UP: d.pup = reg_wdata[PULL_W-1:0];
				default: d.cfg = q.cfg;
			endcase
		end
		if (reg_re) begin
			case (reg_addr)
				REG_CONFIG: d.rdata = DATA_W'(q.cfg);
				REG_DRIVE: d.rdata = DATA_W'(q.drv);
				REG_PULL_EN: d.rdata = DATA_W'(q.pen);
				REG_PULL_UP: d.rdata = DATA_W'(q.pup);
				REG_STATUS: begin
					d.rdata[ST_IF_LSB +: 2] = q.if_strap;
					d.rdata[ST_CLK_LSB +: 2] = q.clk_strap;
					d.rdata[ST_ASYNC] = q.async_mode;
					d.rdata[ST_BUSY] = (q.phase == PM_CAPTURE);
				end
				default: d.rdata = '0;
			endcase
		end

		if (!nrst) begin
			d = '0;
			d.phase = PM_CAPTURE;
			d.cap_cnt = CAP_LOAD;
			d.sp_pd = 4'hF;
			d.size_n = 1'b1;
			d.rx_trx = 2'h3;
			d.rx_diff = 2'h3;
			d.cfg = CFG_RESET;
			d.drv = DRV_RESET;
			d.pen = PULL_RESET;
			d.pup = PULL_RESET;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata = q.rdata;
	assign data_pin_out = q.dout;
	assign data_pin_oe = q.doe;
	assign async_memory_host_mode = q.async_mode;
	assign mem_addr = q.maddr;
	assign mem_wdata = q.mwdata;
	assign mem_we = q.mwe;
	assign size_select_n = q.size_n;
	assign expanded_address_line = q.xal;
	assign address_select_input = q.asel;
	assign mux_ad = q.ad;
	assign low_byte_strobe = q.lbs;
	assign read_write_select = q.rw;
	assign host_bus_clock = q.hclk;
	assign strap_pin_out = q.sp_out;
	assign strap_pin_oe = q.sp_oe;
	assign strap_pin_pd = q.sp_pd;
	assign external_clock_output = q.ckout;
	assign transceiver_receive_data = q.rx_trx;
	assign differential_receive_data = q.rx_diff;
	assign drive_reduced = q.drv;
	assign pull_enable = q.pen;
	assign pull_up_select = q.pup;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_oe_gates_data;
		(q.phase == PM_RUN && q.async_mode && q.s2[SY_OE]) |=> !data_pin_oe;
	endproperty
	a_oe_gates_data: assert property (p_oe_gates_data)
		else $error("data pins driven without read enable");

	property p_strap_release;
		(q.phase == PM_CAPTURE) |-> (strap_pin_oe == 4'h0 && strap_pin_pd == 4'hF);
	endproperty
	a_strap_release: assert property (p_strap_release)
		else $error("strap pin driven while latching");

	property p_strap_latch;
		(q.phase == PM_CAPTURE && q.cap_cnt == '0) |=>
			(q.if_strap == $past(q.s2[SY_STRAP +: 2]) && q.phase == PM_RUN);
	endproperty
	a_strap_latch: assert property (p_strap_latch)
		else $error("interface strap not latched at window end");

	property p_reset_pads;
		$rose(nrst) |-> (drive_reduced == '0 && pull_enable == '0);
	endproperty
	a_reset_pads: assert property (p_reset_pads)
		else $error("pads not at full drive and no pull after reset");

	property p_rx_route;
		(q.cfg[CFG_LDT_LSB +: 2] == LDT_TRANSCEIVER) ##1
			(q.cfg[CFG_LDT_LSB +: 2] == LDT_TRANSCEIVER) |->
			transceiver_receive_data == $past(q.s2[SY_RX +: 2]);
	endproperty
	a_rx_route: assert property (p_rx_route)
		else $error("receive channel not routed to transceiver");

	property p_write_pulse;
		(q.phase == PM_RUN && q.async_mode && we_rise) |=> mem_we ##1 !mem_we;
	endproperty
	a_write_pulse: assert property (p_write_pulse)
		else $error("write strobe did not give one capture pulse");

	property p_debug_pick;
		(q.phase == PM_RUN && q.cfg[CFG_STB1_EN]) |=>
			strap_pin_out[SP_ARM] == $past(debug_event[stb1_sel]);
	endproperty
	a_debug_pick: assert property (p_debug_pick)
		else $error("debug strobe one shows wrong event");

	property p_tick_active;
		(q.phase == PM_RUN && !q.cfg[CFG_STB2_EN]) |=>
			strap_pin_out[SP_TICK] == $past(guardian_tick_out) && strap_pin_oe[SP_TICK];
	endproperty
	a_tick_active: assert property (p_tick_active)
		else $error("guardian tick not on its pin");

	property p_clk_toggle;
		$changed(q.ckout) |-> q.div_cnt == div_half($past(q.clk_strap)) - 8'h01;
	endproperty
	a_clk_toggle: assert property (p_clk_toggle)
		else $error("clock output toggled off its divider");

	property p_mux_addr;
		(q.phase == PM_RUN && !q.async_mode) |=>
			expanded_address_line == $past(q.s2[SY_ADDR +: 6]) && !data_pin_oe == !$past(mux_drive_req);
	endproperty
	a_mux_addr: assert property (p_mux_addr)
		else $error("expanded address lines not passed in mux mode");

endmodule : pm_pin_mux

// *** tb/pm_far_model.sv ***
/*
 * Far-side model: host data bus and strap resistors on the shared pins.
 * Assumes the bench sets the host drive and the strap resistor levels.
 */
module pm_far_model (
	// Device pad side
	input wire logic [15:0] data_pin_out,
	input wire logic data_pin_oe,
	input wire logic [3:0] strap_pin_out,
	input wire logic [3:0] strap_pin_oe,
	// Host and board side
	input wire logic [15:0] host_d,
	input wire logic host_den,
	input wire logic [3:0] strap_lv,
	// Resolved wires
	output logic [15:0] data_wire,
	output logic [3:0] strap_wire
);
	timeunit 1ns;
	timeprecision 1ps;

	// --------------------------------------------------------
	// Wire resolution
	// --------------------------------------------------------
	// Data bus driven by neither side shows the inverse of the host data, host_d only while host_den is set
	assign data_wire = data_pin_oe ? data_pin_out : (host_den ? host_d : ~host_d);
	// Board resistors outweigh the weak internal pulldown
	for (genvar i = 0; i < 4; i++) begin : g_strap
		assign strap_wire[i] = strap_pin_oe[i] ? strap_pin_out[i] : strap_lv[i];
	end
endmodule : pm_far_model

// *** tb/pm_pin_mux_test.sv ***
/*
 * Self-checking bench of the pin function multiplexer.
 * Assumes the design's default lookup tables and a 40 MHz clock.
 */
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module pm_pin_mux_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pm_pkg::*;

	logic clk = 0, nrst = 0, reg_we = 0, reg_re = 0, oe_n = 1, ce = 1, we = 1, hclk = 0;
	logic mux_req = 0, tick = 0, mtick = 1, arm = 0, tx1 = 1, den = 0;
	logic [3:0] reg_addr = 0, strap_lv = 0, s_out, s_oe, s_pd, s_wire;
	logic [15:0] reg_wdata = 0, d_out, rdata, host_d = 0, d_wire, mem_rdata = 16'hBEEF, rd;
	logic [5:0] a_pin = 0, xal, asel, drv;
	logic [2:0] sel_lo = 0;
	logic [1:0] sel_hi = 0, rx = 0, trx, drx;
	logic [7:0] dbg_ev = 8'hA5;
	logic [8:0] maddr, pen, pup;
	logic [15:0] mwd, mad;
	logic d_oe, amode, mwe, ssel_n, lbs, rws, hbc, ckout, last;
	int n_mismatch = 0, n_compared = 0, cyc = 0, k;

	pm_pin_mux dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(rdata), .addr_pin_in(a_pin),
		.asel_low_pin_in(sel_lo), .oe_asel3_pin_in(oe_n), .asel_high_pin_in(sel_hi),
		.data_pin_in(d_wire), .data_pin_out(d_out), .data_pin_oe(d_oe), .ce_lbs_pin_in(ce),
		.we_rw_pin_in(we), .host_bus_clock_in(hclk), .async_memory_host_mode(amode),
		.mem_addr(maddr), .mem_wdata(mwd), .mem_we(mwe), .size_select_n(ssel_n),
		.mem_rdata(mem_rdata), .expanded_address_line(xal), .address_select_input(asel),
		.mux_ad(mad), .low_byte_strobe(lbs), .read_write_select(rws), .host_bus_clock(hbc),
		.mux_drive_req(mux_req), .guardian_tick_out(tick), .guardian_macrotick_out(mtick),
		.guardian_arm_out(arm), .tx_data_one(tx1), .debug_event(dbg_ev), .strap_pin_in(s_wire),
		.strap_pin_out(s_out), .strap_pin_oe(s_oe), .strap_pin_pd(s_pd),
		.external_clock_output(ckout), .rx_pin_in(rx), .transceiver_receive_data(trx),
		.differential_receive_data(drx), .drive_reduced(drv), .pull_enable(pen),
		.pull_up_select(pup));
	pm_far_model far (.data_pin_out(d_out), .data_pin_oe(d_oe), .strap_pin_out(s_out),
		.strap_pin_oe(s_oe), .host_d(host_d), .host_den(den), .strap_lv(strap_lv),
		.data_wire(d_wire), .strap_wire(s_wire));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// --------------------------------------------------------
	// Timeout
	// --------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask : cycles

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_we <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 0;
	endtask : wr

	task automatic rdreg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_re <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 0;
		#1 d = rdata;
	endtask : rdreg

	// Reset with straps held; checks pad state in reset and once inside the capture window
	task automatic do_reset(input logic [3:0] lv);
		@(posedge clk);
		nrst <= 0;
		strap_lv <= lv;
		cycles(12);
		`CHK(drv, 6'h00)
		`CHK(pen, 9'h000)
		nrst <= 1;
		cycles(3);
		`CHK(s_oe, 4'h0)
		`CHK(s_pd, 4'hF)
		cycles(15);
	endtask : do_reset

	// Half period of the external clock output, in core cycles
	task automatic half_period(output int n);
		@(posedge clk);
		last = ckout;
		k = 0;
		while (ckout === last && k < 40) begin @(posedge clk); k++; end
		last = ckout;
		n = 0;
		while (ckout === last && n < 40) begin @(posedge clk); n++; end
	endtask : half_period

	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	initial begin
		int hp;
		// ----------------------------------------------------
		// Async memory port: interface code 0, clock code 1
		// ----------------------------------------------------
		do_reset(4'h4);
		rdreg(REG_STATUS, rd);
		`CHK(rd, 16'h0014)
		`CHK(amode, 1'b1)
		`CHK(xal, 6'h00)
		half_period(hp);
		`CHK(hp, 2)
		// Host write, word LSB at bit zero
		a_pin <= 6'h2D;
		sel_lo <= 3'h5;
		host_d <= 16'h8001;
		den <= 1;
		ce <= 0;
		we <= 0;
		cycles(6);
		`CHK(ssel_n, 1'b0)
		we <= 1;
		k = 0;
		while (mwe !== 1'b1 && k < 10) begin @(posedge clk); k++; end
		`CHK(maddr, 9'h16D)
		`CHK(mwd, 16'h8001)
		den <= 0;
		// Host read: pins driven only while output enable is low
		oe_n <= 0;
		cycles(5);
		`CHK(d_oe, 1'b1)
		`CHK(d_wire, 16'hBEEF)
		oe_n <= 1;
		cycles(5);
		`CHK(d_oe, 1'b0)
		ce <= 1;
		$display("test async done");
		// ----------------------------------------------------
		// Registers: drive, pulls, refusals
		// ----------------------------------------------------
		wr(REG_DRIVE, 16'h003F);
		rdreg(REG_DRIVE, rd);
		`CHK(rd, 16'h003F)
		`CHK(drv, 6'h3F)
		wr(REG_PULL_EN, 16'h01FF);
		wr(REG_PULL_UP, 16'h0155);
		// Last write lands on the edge the task returns at
		cycles(1);
		`CHK(pen, 9'h1FF)
		`CHK(pup, 9'h155)
		wr(REG_STATUS, 16'hFFFF);
		rdreg(REG_STATUS, rd);
		`CHK(rd, 16'h0014)
		rdreg(4'hF, rd);
		`CHK(rd, 16'h0000)
		$display("test registers done");
		// ----------------------------------------------------
		// Receive routing and guardian/debug sharing
		// ----------------------------------------------------
		rx <= 2'b01;
		cycles(5);
		`CHK(trx, 2'b01)
		`CHK(drx, 2'b11)
		wr(REG_CONFIG, 16'h0001);
		rx <= 2'b10;
		cycles(5);
		`CHK(drx, 2'b10)
		`CHK(trx, 2'b11)
		arm <= 1;
		tick <= 1;
		cycles(4);
		`CHK(s_out[SP_ARM], 1'b1)
		`CHK(s_out[SP_MACROTICK], 1'b1)
		`CHK(s_oe, 4'hF)
		for (int i = 0; i < 8; i++) begin
			wr(REG_CONFIG, 16'(10'h301 | (i << 2) | ((7 - i) << 5)));
			cycles(4);
			`CHK(s_out[SP_ARM], dbg_ev[i])
			`CHK(s_out[SP_TICK], dbg_ev[7-i])
		end
		$display("test sharing done");
		// ----------------------------------------------------
		// Multiplexed bus: interface code 1, clock code 2
		// ----------------------------------------------------
		do_reset(4'h9);
		`CHK(amode, 1'b0)
		half_period(hp);
		`CHK(hp, 4)
		a_pin <= 6'h2A;
		sel_lo <= 3'h3;
		oe_n <= 1;
		sel_hi <= 2'b10;
		host_d <= 16'h1234;
		den <= 1;
		ce <= 1;
		we <= 1;
		cycles(6);
		`CHK(xal, 6'h2A)
		`CHK(asel, 6'h2B)
		`CHK(mad, 16'h1234)
		`CHK(lbs, 1'b1)
		`CHK(rws, 1'b1)
		`CHK(mwe, 1'b0)
		den <= 0;
		mux_req <= 1;
		cycles(3);
		`CHK(d_oe, 1'b1)
		mux_req <= 0;
		// Host clock of 6.67 MHz, under the 8 MHz ceiling
		for (int i = 0; i < 6; i++) begin
			hclk <= ~hclk;
			cycles(3);
			last = hbc;
			hclk <= ~hclk;
			cycles(3);
			`CHK(hbc, ~last)
		end
		$display("test mux done");
		results();
	end
endmodule : pm_pin_mux_test
